// ==== reset_source_controller_test.sv ====
// Testbench of the reset source controller walking each cause in turn with random cold/warm routing.
// Assumes rsc_pkg, rsc_top, rsc_chk and rsc_src_model compile first.
`default_nettype none
module reset_source_controller_test;
	import rsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, strap = 1;
	logic [7:0]  paddr = '0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] pwdata = '0, prdata, q, r;
	logic [12:0] src = '0, lvl;
	logic        pready, pslverr, supply_good, external_reset_pin_n, e, irq;
	logic        cold_rst, warm_rst, lock_clear;
	logic        option_bytes_reload_full, option_bytes_reload_part;
	logic [15:0] module_rst;
	integer      error_cnt = 0, samples_checked = 0, seed = 77498;

	always #5 clk = ~clk;

	rsc_src_model src_m (.src, .supply_good, .external_reset_pin_n, .lvl);
	rsc_top #(.HOLD_CYC(2)) dut (.clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .supply_good,
		.low_voltage_reset(lvl[1]), .brownout_detector_0(lvl[2]),
		.brownout_detector_1(lvl[3]), .external_reset_pin_n,
		.independent_watchdog(lvl[6]), .window_watchdog(lvl[7]),
		.adc_reset(lvl[8]), .comparator_reset(lvl[9]),
		.illegal_address_error(lvl[10]), .flash_protect_error(lvl[11]),
		.missing_clock_detector(lvl[12]), .option_bytes_pin_is_reset(strap),
		.cold_rst, .warm_rst, .lock_clear, .option_bytes_reload_full,
		.option_bytes_reload_part, .module_rst, .irq);

	task automatic chk(input string n, input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wt(input logic v);
		for (int t = 0; t < 60 && warm_rst !== v; t++)
			@(posedge clk);
	endtask

	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("cold", cold_rst, 1);
		apb(0, OFS_FLAGS, 0);
		chk("flags", q, 1);
		wt(0);
		apb(1, OFS_FLAGS, 32'h1FFF);
		for (int i = 0; i < 13; i++) begin
			r = $random(seed);
			apb(1, r[0] ? OFS_COLD_EN : OFS_WARM_EN, 32'h1 << i);
			if (i == 5)
				apb(1, OFS_CTRL, 32'h2);
			else
				src <= 13'h1 << i;
			wt(1);
			chk("cold", cold_rst, r[0] | (i == 0));
			src <= '0;
			wt(0);
			apb(1, OFS_MASK, r[1] ? 32'h1FFF : 0);
			apb(0, OFS_FLAGS, 0);
			chk("flags", q, 32'h1 << i);
			chk("irq", irq, r[1]);
			apb(1, OFS_FLAGS, 32'h1FFF);
			apb(0, OFS_STATE, 0);
			chk("state", q, 0);
			chk("irq", irq, 0);
		end
		strap <= 1'b0;
		apb(1, OFS_WARM_EN, 32'h10);
		src <= 13'h10;
		repeat (20) @(posedge clk);
		chk("warm", warm_rst, 0);
		src <= '0;
		repeat (8) @(posedge clk);
		strap <= 1'b1;
		apb(0, OFS_FLAGS, 0);
		chk("flags", q, 0);
		r = $random(seed);
		apb(1, OFS_MOD_RST, r);
		apb(0, OFS_MOD_RST, 0);
		chk("modrd", q, r & 32'hFFFF);
		chk("mod", module_rst, r[15:0]);
		chk("warm", warm_rst, 0);
		apb(0, 8'h40, 0);
		chk("err", e, 1);
		apb(1, OFS_COLD_EN, 0);
		apb(1, OFS_CTRL, 32'h1);
		apb(1, OFS_WARM_EN, 32'h1FFE);
		src <= 13'h10;
		wt(1);
		repeat (20) @(posedge clk);
		chk("warm", warm_rst, 1);
		src <= '0;
		wt(0);
		apb(0, OFS_WARM_EN, 0);
		chk("warmen", q, 32'h10);
		stop_test;
	end

	initial begin
		#200000;
		error_cnt++;
		stop_test;
	end
endmodule : reset_source_controller_test

bind rsc_top rsc_chk #(.NMOD(NMOD), .HOLD_CYC(HOLD_CYC)) chk_i (.clk, .srst,
	.supply_good, .cold_rst, .warm_rst, .lock_clear, .option_bytes_reload_full,
	.option_bytes_reload_part, .module_rst);
`default_nettype wire

// ==== rsc_chk.sv ====
// Checker of the reset outputs of the reset source controller.
// Assumes it is bound to rsc_top and sees that module's parameters.
`default_nettype none
module rsc_chk
	import rsc_pkg::*;
#(
	parameter int unsigned NMOD     = 16,
	parameter int unsigned HOLD_CYC = 2
) (
	// Clock and reset
	input wire logic            clk,
	input wire logic            srst,
	// Supply cause
	input wire logic            supply_good,
	// Reset outputs
	input wire logic            cold_rst,
	input wire logic            warm_rst,
	input wire logic            lock_clear,
	input wire logic            option_bytes_reload_full,
	input wire logic            option_bytes_reload_part,
	input wire logic [NMOD-1:0] module_rst
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	a_por_cold: assert property (!supply_good [*6] |-> cold_rst)
		else $error("cold reset missing while supply is bad");
	a_cold_warm: assert property (cold_rst |-> warm_rst)
		else $error("cold reset without warm reset");
	a_lock_clr: assert property (lock_clear == cold_rst)
		else $error("lock clear differs from cold reset");
	a_cold_hold: assert property ($rose(cold_rst) |-> cold_rst [*2])
		else $error("cold reset released too early");
	a_warm_lag: assert property ($fell(cold_rst) |-> warm_rst [*2])
		else $error("warm reset not stretched after cold");
	a_full_load: assert property ($fell(cold_rst) |-> ##[0:1] option_bytes_reload_full)
		else $error("full option reload missing");
	a_part_load: assert property ($fell(warm_rst) |-> ##[0:1] option_bytes_reload_part)
		else $error("partial option reload missing");
	a_mod_clr: assert property (warm_rst [*3] |-> module_rst == '0)
		else $error("module resets not cleared by warm reset");
	c_cold: cover property ($fell(cold_rst));
	c_warm: cover property ($rose(warm_rst) && !cold_rst);
	c_por: cover property ($fell(supply_good));
endmodule : rsc_chk
`default_nettype wire

// ==== rsc_pkg.sv ====
// Constants shared by the reset source controller.
// Assumes a 100 MHz system clock and an APB register bus with 32-bit data.
`default_nettype none
package rsc_pkg;
	// Clock rate and reset stretch time
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned RST_HOLD_NS  = 80;
	localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_PER_US + 999) / 1000;

	// Reset source indices
	localparam int unsigned NSRC       = 13;
	localparam int unsigned SRC_POR    = 0;
	localparam int unsigned SRC_LVR    = 1;
	localparam int unsigned SRC_BROWNOUT_DETECTOR_0   = 2;
	localparam int unsigned SRC_BROWNOUT_DETECTOR_1   = 3;
	localparam int unsigned SRC_EXT    = 4;
	localparam int unsigned SRC_SW     = 5;
	localparam int unsigned SRC_IWDG   = 6;
	localparam int unsigned SRC_WWDG   = 7;
	localparam int unsigned SRC_ADC    = 8;
	localparam int unsigned SRC_CMP    = 9;
	localparam int unsigned SRC_IAE    = 10;
	localparam int unsigned SRC_FLASH  = 11;
	localparam int unsigned SRC_MCLK   = 12;

	// Register byte offsets
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0] OFS_FLAGS   = 8'h00;
	localparam logic [7:0] OFS_MASK    = 8'h04;
	localparam logic [7:0] OFS_COLD_EN = 8'h08;
	localparam logic [7:0] OFS_WARM_EN = 8'h0C;
	localparam logic [7:0] OFS_CTRL    = 8'h10;
	localparam logic [7:0] OFS_MOD_RST = 8'h14;
	localparam logic [7:0] OFS_STATE   = 8'h18;

	// Control register fields
	localparam int unsigned CTRL_LOCK  = 0;
	localparam int unsigned CTRL_FORCE = 1;
	// State register fields
	localparam int unsigned STATE_COLD = 13;
	localparam int unsigned STATE_WARM = 14;

	// Reset values and writable enable bits
	localparam logic [12:0] FLAGS_RST   = 13'h0001;
	localparam logic [12:0] MASK_RST    = 13'h0000;
	localparam logic [12:0] COLD_EN_RST = 13'h0000;
	localparam logic [12:0] WARM_EN_RST = 13'h0000;
	localparam logic [12:0] EN_WMASK    = 13'h1FFE;
endpackage : rsc_pkg
`default_nettype wire

// ==== rsc_src_model.sv ====
// Model of the reset causes outside the controller.
// Assumes src holds one active high request per source index.
`default_nettype none
module rsc_src_model (
	// Cause requests
	input  wire logic [12:0] src,
	// Cause levels to the controller
	output logic             supply_good,
	output logic             external_reset_pin_n,
	output logic      [12:0] lvl
);
	assign supply_good          = ~src[0];
	assign external_reset_pin_n = ~src[4];
	assign lvl                  = src;
endmodule : rsc_src_model
`default_nettype wire

// ==== rsc_top.sv ====
// Reset source controller: merges reset causes into cold and warm resets,
// keeps sticky cause flags, per-module soft resets, APB slave and interrupt.
// Assumes cause inputs are asynchronous levels and the option-byte strap is
// a stable level on clk.
// Behaviour
// [RQ1] Power-on outranks cold reset, cold outranks warm reset.
// [RQ2] Power-on reset always drives the cold reset output.
// [RQ3] Cold reset always drives the warm reset output.
// [RQ4] Power-on reset holds while supply is not good, returns when lost.
// [RQ5] Cold reset reloads all option bytes and clears register locks.
// [RQ6] Cold reset output feeds watchdogs, calendar, power, clock, memory units.
// [RQ7] Warm reset output reaches every bus module, clearing its state.
// [RQ8] Warm reset reloads part of option bytes; locked registers kept.
// [RQ9] Warm reset clears warm source enables unless the lock is engaged.
// [RQ10] Device stays in reset while the external pin is held low.
// [RQ11] Option-byte strap alone decides whether the pin acts as reset; here its cold or warm enable bit must also be set.
// [RQ12] Per-source event flags show software what caused the reset.
// [RQ13] Accepts power, voltage, brown-out, pin, software, watchdog, ADC, comparator.
// [RQ14] Accepts illegal address, flash protect and missing clock causes.
// [RQ15] Each source is enabled for cold reset, warm reset or neither.
// [RQ16] Software resets any single module without a chip reset.
// [RQ17] During reset registers take initial values; processor restarts.
// [RQ18] Event flags survive warm and cold resets until software clears them.
// [RQ19] Reset outputs release synchronously after a few stretch cycles.
//
// Chosen here: the register offsets and the APB slave port.
`default_nettype none
module rsc_top
	import rsc_pkg::*;
#(
	parameter int unsigned NMOD     = 16,
	parameter int unsigned HOLD_CYC = RST_HOLD_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Reset causes
	input  wire logic              supply_good,
	input  wire logic              low_voltage_reset,
	input  wire logic              brownout_detector_0,
	input  wire logic              brownout_detector_1,
	input  wire logic              external_reset_pin_n,
	input  wire logic              independent_watchdog,
	input  wire logic              window_watchdog,
	input  wire logic              adc_reset,
	input  wire logic              comparator_reset,
	input  wire logic              illegal_address_error,
	input  wire logic              flash_protect_error,
	input  wire logic              missing_clock_detector,
	// Option-byte strap
	input  wire logic              option_bytes_pin_is_reset,
	// Reset outputs
	output logic                   cold_rst,
	output logic                   warm_rst,
	output logic                   lock_clear,
	output logic                   option_bytes_reload_full,
	output logic                   option_bytes_reload_part,
	output logic      [NMOD-1:0]   module_rst,
	// Interrupt
	output logic                   irq
);

	if (NMOD < 1 || NMOD > 32) begin : g_bad_nmod
		$error("NMOD must lie in 1..32");
	end
	if (HOLD_CYC < 1 || HOLD_CYC > 255) begin : g_bad_hold
		$error("HOLD_CYC must lie in 1..255");
	end
	if (NSRC != 13) begin : g_bad_nsrc
		$error("NSRC must match the 13-bit reset constants");
	end

	localparam int unsigned CW = 8;
	localparam logic [CW-1:0] HOLD = CW'(HOLD_CYC);

	typedef struct packed {
		logic [NSRC-1:0] s1;
		logic [NSRC-1:0] s2;
		logic [NSRC-1:0] s3;
		logic [NSRC-1:0] lvl;
		logic [NSRC-1:0] act;
		logic [NSRC-1:0] flags;
		logic [NSRC-1:0] mask;
		logic [NSRC-1:0] cold_en;
		logic [NSRC-1:0] warm_en;
		logic            lock;
		logic            sw_req;
		logic [NMOD-1:0] mod_rst;
		logic [CW-1:0]   cold_cnt;
		logic [CW-1:0]   warm_cnt;
		logic            cold;
		logic            warm;
		logic            ob_full;
		logic            ob_part;
		logic            irq;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} rsc_state_t;

	localparam rsc_state_t ST_RST = '{
		s1:       '0,
		s2:       '0,
		s3:       '0,
		lvl:      '0,
		act:      '0,
		flags:    FLAGS_RST,
		mask:     MASK_RST,
		cold_en:  COLD_EN_RST,
		warm_en:  WARM_EN_RST,
		lock:     1'b0,
		sw_req:   1'b0,
		mod_rst:  '0,
		cold_cnt: HOLD,
		warm_cnt: HOLD,
		cold:     1'b1,
		warm:     1'b1,
		ob_full:  1'b0,
		ob_part:  1'b0,
		irq:      1'b0,
		pready:   1'b0,
		pslverr:  1'b0,
		prdata:   '0
	};

	rsc_state_t q;
	rsc_state_t d;

	logic [NSRC-1:0] raw;
	logic [NSRC-1:0] src;
	logic [31:0]     wmask;
	logic [31:0]     wval;
	logic            cold_req;
	logic            warm_req;
	logic            acc;
	logic            take;
	logic            wr;

	// Raw cause vector, pin and supply inverted to active high
	always_comb begin
		raw             = '0;
		raw[SRC_POR]    = ~supply_good; // RQ4
		raw[SRC_LVR]    = low_voltage_reset; // RQ13
		raw[SRC_BROWNOUT_DETECTOR_0]   = brownout_detector_0;
		raw[SRC_BROWNOUT_DETECTOR_1]   = brownout_detector_1;
		raw[SRC_EXT]    = ~external_reset_pin_n; // RQ10
		raw[SRC_IWDG]   = independent_watchdog;
		raw[SRC_WWDG]   = window_watchdog;
		raw[SRC_ADC]    = adc_reset;
		raw[SRC_CMP]    = comparator_reset;
		raw[SRC_IAE]    = illegal_address_error; // RQ14
		raw[SRC_FLASH]  = flash_protect_error;
		raw[SRC_MCLK]   = missing_clock_detector;
	end

	always_comb begin
		d        = q;
		src      = '0;
		wmask    = '0;
		wval     = '0;
		cold_req = 1'b0;
		warm_req = 1'b0;
		acc      = psel & penable;
		take     = acc & q.pready;
		wr       = take & pwrite;

		// Three-stage synchroniser, level taken once stages two and three agree
		d.s1 = raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < NSRC; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s3[i];
			end
		end

		// Qualified sources
		src          = q.lvl;
		src[SRC_EXT] = q.lvl[SRC_EXT] & option_bytes_pin_is_reset; // RQ11
		src[SRC_SW]  = q.sw_req;

		// Routing: power-on always cold, other sources per enable
		cold_req = src[SRC_POR] | (|(src & q.cold_en & EN_WMASK)); // RQ1 RQ2 RQ15
		warm_req = |(src & q.warm_en & EN_WMASK); // RQ15

		// Cold reset with synchronous stretched release
		if (cold_req) begin
			d.cold_cnt = HOLD;
		end else if (q.cold_cnt != '0) begin
			d.cold_cnt = q.cold_cnt - CW'(1); // RQ19
		end
		d.cold = cold_req | (q.cold_cnt != '0); // RQ4 RQ10 RQ6

		// Warm reset follows any cold reset
		if (d.cold | warm_req) begin
			d.warm_cnt = HOLD; // RQ3
		end else if (q.warm_cnt != '0) begin
			d.warm_cnt = q.warm_cnt - CW'(1); // RQ19
		end
		d.warm = d.cold | warm_req | (q.warm_cnt != '0); // RQ3 RQ7 RQ17

		// Option-byte reload strobes at release
		d.ob_full = q.cold & ~d.cold; // RQ5
		d.ob_part = q.warm & ~d.warm; // RQ8

		// Sticky cause flags, rising edge of each source
		d.act = src;
		d.sw_req = 1'b0;

		// APB: ready one cycle into the access phase
		d.pready  = acc & ~q.pready;
		d.pslverr = 1'b0;
		if (acc & ~q.pready) begin
			d.prdata = '0;
			case (paddr)
				OFS_FLAGS: begin
					d.prdata[NSRC-1:0] = q.flags; // RQ12
				end
				OFS_MASK: begin
					d.prdata[NSRC-1:0] = q.mask;
				end
				OFS_COLD_EN: begin
					d.prdata[NSRC-1:0] = q.cold_en;
				end
				OFS_WARM_EN: begin
					d.prdata[NSRC-1:0] = q.warm_en;
				end
				OFS_CTRL: begin
					d.prdata[CTRL_LOCK] = q.lock;
				end
				OFS_MOD_RST: begin
					d.prdata[NMOD-1:0] = q.mod_rst;
				end
				OFS_STATE: begin
					d.prdata[NSRC-1:0]  = src;
					d.prdata[STATE_COLD] = q.cold;
					d.prdata[STATE_WARM] = q.warm;
				end
				default: begin
					d.pslverr = 1'b1;
				end
			endcase
		end

		// Byte-lane write mask
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{pstrb[b]}};
		end
		wval = pwdata & wmask;

		d.flags = q.flags;
		if (wr && paddr == OFS_FLAGS) begin
			d.flags = q.flags & ~wval[NSRC-1:0];
		end
		d.flags = d.flags | (src & ~q.act); // RQ12 RQ18

		if (wr) begin
			case (paddr)
				OFS_MASK: begin
					d.mask = (q.mask & ~wmask[NSRC-1:0]) | wval[NSRC-1:0];
				end
				OFS_COLD_EN: begin
					if (!q.lock) begin
						d.cold_en = ((q.cold_en & ~wmask[NSRC-1:0]) | wval[NSRC-1:0])
							& EN_WMASK; // RQ15
					end
				end
				OFS_WARM_EN: begin
					if (!q.lock) begin
						d.warm_en = ((q.warm_en & ~wmask[NSRC-1:0]) | wval[NSRC-1:0])
							& EN_WMASK; // RQ15
					end
				end
				OFS_CTRL: begin
					if (wval[CTRL_LOCK]) begin
						d.lock = 1'b1;
					end
					d.sw_req = wval[CTRL_FORCE];
				end
				OFS_MOD_RST: begin
					d.mod_rst = (q.mod_rst & ~wmask[NMOD-1:0]) | wval[NMOD-1:0]; // RQ16
				end
				default: begin
				end
			endcase
		end

		// Warm release clears warm enables when unlocked
		if (q.warm && !d.warm && !q.lock) begin
			d.warm_en = '0; // RQ9
		end
		// Warm reset clears module soft resets
		if (q.warm) begin
			d.mod_rst = '0; // RQ7
		end
		// Cold reset clears the lock
		if (d.cold) begin
			d.lock = 1'b0; // RQ5
		end

		d.irq = |(d.flags & d.mask);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= ST_RST; // RQ17
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign prdata                   = q.prdata;
	assign pready                   = q.pready;
	assign pslverr                  = q.pslverr;
	assign cold_rst                 = q.cold; // RQ6
	assign warm_rst                 = q.warm; // RQ7
	assign lock_clear               = q.cold; // RQ5
	assign option_bytes_reload_full = q.ob_full;
	assign option_bytes_reload_part = q.ob_part;
	assign module_rst               = q.mod_rst;
	assign irq                      = q.irq;

endmodule // rsc_top
`default_nettype wire
